// ==== design/iprb_pkg.sv ====
// Package with register map, field layout and types of the interrupt priority bank.
// Functional notes
// - Three-bit priority, higher code more urgent
// - Priority code zero disables the source
// - Every priority field resets to level four
// - Unimplemented priority bits read as zero
// - Priority fields are readable and writable
// - Register one: timer, compare, capture fields
// - Register two: serial rx, sync serial, timer
// - Register three: converter and serial tx fields
// - Register four: pin change and two-wire fields
// - Register five: captures h, g, external pin
// - Register seven: external pin c only
// - Register sixteen: serial error only
// - Flag set on request; only flagged arbitrate
// - Cleared enable bit blocks the request
package iprb_pkg;
   localparam int NSRC = 17;
   localparam logic [2:0] PRIO_RESET = 3'h4;
   localparam logic [2:0] PRIO_OFF = 3'h0;
   // Register byte addresses on the bus.
   localparam logic [11:0] ADDR_PRIO1 = 12'h000;
   localparam logic [11:0] ADDR_PRIO2 = 12'h004;
   localparam logic [11:0] ADDR_PRIO3 = 12'h008;
   localparam logic [11:0] ADDR_PRIO4 = 12'h00C;
   localparam logic [11:0] ADDR_PRIO5 = 12'h010;
   localparam logic [11:0] ADDR_PRIO7 = 12'h014;
   localparam logic [11:0] ADDR_PRIO16 = 12'h018;
   localparam logic [11:0] ADDR_FLAG = 12'h020;
   localparam logic [11:0] ADDR_ENABLE = 12'h024;
   localparam logic [11:0] ADDR_CPU_LEVEL = 12'h028;
   localparam logic [11:0] ADDR_STATUS = 12'h02C;
   // Source index: order gives the fixed tie position.
   localparam int S_TIMER_B = 0;
   localparam int S_COMPARE_B = 1;
   localparam int S_CAPTURE_B = 2;
   localparam int S_SERIAL_RX = 3;
   localparam int S_SYNC_EVT = 4;
   localparam int S_SYNC_ERR = 5;
   localparam int S_TIMER_C = 6;
   localparam int S_CONV_DONE = 7;
   localparam int S_SERIAL_TX = 8;
   localparam int S_PIN_CHANGE = 9;
   localparam int S_TW_MASTER = 10;
   localparam int S_TW_SLAVE = 11;
   localparam int S_CAPTURE_H = 12;
   localparam int S_CAPTURE_G = 13;
   localparam int S_EXT_B = 14;
   localparam int S_EXT_C = 15;
   localparam int S_SERIAL_ERR = 16;
   // Field low-bit positions inside a 16-bit priority register.
   localparam int F_HI = 12;
   localparam int F_MID = 8;
   localparam int F_LO = 4;
   localparam int F_BOT = 0;
   typedef struct packed {
      logic valid;
      logic [4:0] source;
      logic [2:0] level;
   } iprb_req_s;
endpackage : iprb_pkg

// ==== design/iprb_bank.sv ====
// Interrupt priority bank with flags, enables and arbitration on an APB slave.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module iprb_bank (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [16:0] event_i,
   output iprb_pkg::iprb_req_s req_o,
   output logic irq_o
);
   localparam int N = iprb_pkg::NSRC;
   logic [2:0] prio [N];
   logic [N-1:0] flag;
   logic [N-1:0] enable;
   logic [2:0] cpu_level;
   logic wr;
   logic rd;
   logic hit;
   logic ack;
   logic [2:0] won_prio;
   logic [31:0] next_rdata;
   iprb_pkg::iprb_req_s next_req;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   assign wr = psel_i & penable_i & pwrite_i & ack;
   assign rd = psel_i & penable_i & ~pwrite_i & ack;
   assign pready_o = psel_i & penable_i & ack;

   function automatic logic [15:0] fld(input logic [2:0] v, input int pos);
      fld = 16'(v) << pos;
   endfunction : fld

   always_comb begin
      next_rdata = 32'h0;
      hit = 1'b1;
      case (paddr_i)
         iprb_pkg::ADDR_PRIO1: next_rdata[15:0] = fld(prio[iprb_pkg::S_TIMER_B], iprb_pkg::F_HI)
            | fld(prio[iprb_pkg::S_COMPARE_B], iprb_pkg::F_MID) | fld(prio[iprb_pkg::S_CAPTURE_B], iprb_pkg::F_LO);
         iprb_pkg::ADDR_PRIO2: next_rdata[15:0] = fld(prio[iprb_pkg::S_SERIAL_RX], iprb_pkg::F_HI)
            | fld(prio[iprb_pkg::S_SYNC_EVT], iprb_pkg::F_MID) | fld(prio[iprb_pkg::S_SYNC_ERR], iprb_pkg::F_LO)
            | fld(prio[iprb_pkg::S_TIMER_C], iprb_pkg::F_BOT);
         iprb_pkg::ADDR_PRIO3: next_rdata[15:0] = fld(prio[iprb_pkg::S_CONV_DONE], iprb_pkg::F_LO)
            | fld(prio[iprb_pkg::S_SERIAL_TX], iprb_pkg::F_BOT);
         iprb_pkg::ADDR_PRIO4: next_rdata[15:0] = fld(prio[iprb_pkg::S_PIN_CHANGE], iprb_pkg::F_HI)
            | fld(prio[iprb_pkg::S_TW_MASTER], iprb_pkg::F_LO) | fld(prio[iprb_pkg::S_TW_SLAVE], iprb_pkg::F_BOT);
         iprb_pkg::ADDR_PRIO5: next_rdata[15:0] = fld(prio[iprb_pkg::S_CAPTURE_H], iprb_pkg::F_HI)
            | fld(prio[iprb_pkg::S_CAPTURE_G], iprb_pkg::F_MID) | fld(prio[iprb_pkg::S_EXT_B], iprb_pkg::F_BOT);
         iprb_pkg::ADDR_PRIO7: next_rdata[15:0] = fld(prio[iprb_pkg::S_EXT_C], iprb_pkg::F_LO);
         iprb_pkg::ADDR_PRIO16: next_rdata[15:0] = fld(prio[iprb_pkg::S_SERIAL_ERR], iprb_pkg::F_LO);
         iprb_pkg::ADDR_FLAG: next_rdata = 32'(flag);
         iprb_pkg::ADDR_ENABLE: next_rdata = 32'(enable);
         iprb_pkg::ADDR_CPU_LEVEL: next_rdata = 32'(cpu_level);
         iprb_pkg::ADDR_STATUS: next_rdata = 32'(req_o);
         default: hit = 1'b0;
      endcase
   end

   // Read data is registered in the first access cycle, so the bank answers one cycle later.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack <= 1'b0;
         prdata_o <= 32'h0;
      end else begin
         ack <= psel_i & penable_i & ~ack;
         prdata_o <= (psel_i & penable_i & ~pwrite_i & ~ack) ? next_rdata : 32'h0;
      end
   end
   assign pslverr_o = pready_o & ~hit;

   task automatic put(input int s, input int pos);
      prio[s] <= pwdata_i[pos +: 3];
   endtask : put

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < N; i++) begin
            prio[i] <= iprb_pkg::PRIO_RESET;
         end
      end else if (wr) begin
         case (paddr_i)
            iprb_pkg::ADDR_PRIO1: begin
               put(iprb_pkg::S_TIMER_B, iprb_pkg::F_HI);
               put(iprb_pkg::S_COMPARE_B, iprb_pkg::F_MID);
               put(iprb_pkg::S_CAPTURE_B, iprb_pkg::F_LO);
            end
            iprb_pkg::ADDR_PRIO2: begin
               put(iprb_pkg::S_SERIAL_RX, iprb_pkg::F_HI);
               put(iprb_pkg::S_SYNC_EVT, iprb_pkg::F_MID);
               put(iprb_pkg::S_SYNC_ERR, iprb_pkg::F_LO);
               put(iprb_pkg::S_TIMER_C, iprb_pkg::F_BOT);
            end
            iprb_pkg::ADDR_PRIO3: begin
               put(iprb_pkg::S_CONV_DONE, iprb_pkg::F_LO);
               put(iprb_pkg::S_SERIAL_TX, iprb_pkg::F_BOT);
            end
            iprb_pkg::ADDR_PRIO4: begin
               put(iprb_pkg::S_PIN_CHANGE, iprb_pkg::F_HI);
               put(iprb_pkg::S_TW_MASTER, iprb_pkg::F_LO);
               put(iprb_pkg::S_TW_SLAVE, iprb_pkg::F_BOT);
            end
            iprb_pkg::ADDR_PRIO5: begin
               put(iprb_pkg::S_CAPTURE_H, iprb_pkg::F_HI);
               put(iprb_pkg::S_CAPTURE_G, iprb_pkg::F_MID);
               put(iprb_pkg::S_EXT_B, iprb_pkg::F_BOT);
            end
            iprb_pkg::ADDR_PRIO7: put(iprb_pkg::S_EXT_C, iprb_pkg::F_LO);
            iprb_pkg::ADDR_PRIO16: put(iprb_pkg::S_SERIAL_ERR, iprb_pkg::F_LO);
            default: ;
         endcase
      end
   end

   // Flags are sticky; writing a one clears, but a same-cycle event keeps the flag set.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag <= '0;
      end else if (wr && paddr_i == iprb_pkg::ADDR_FLAG) begin
         flag <= (flag & ~pwdata_i[N-1:0]) | event_i;
      end else begin
         flag <= flag | event_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable <= '0;
         cpu_level <= 3'h0;
      end else if (wr) begin
         if (paddr_i == iprb_pkg::ADDR_ENABLE) begin
            enable <= pwdata_i[N-1:0];
         end
         if (paddr_i == iprb_pkg::ADDR_CPU_LEVEL) begin
            cpu_level <= pwdata_i[2:0];
         end
      end
   end

   // Strict greater-than keeps the lowest index among equal levels.
   always_comb begin
      next_req = '0;
      for (int i = 0; i < N; i++) begin
         if (flag[i] && enable[i] && prio[i] != iprb_pkg::PRIO_OFF && prio[i] > next_req.level) begin
            next_req.valid = 1'b1;
            next_req.source = 5'(i);
            next_req.level = prio[i];
         end
      end
      if (next_req.level <= cpu_level) begin
         next_req = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_o <= '0;
         won_prio <= 3'h0;
      end else begin
         req_o <= next_req;
         won_prio <= prio[next_req.source];
      end
   end

   assign irq_o = req_o.valid;

   property p_reset_level;
      @(posedge clk_i) $fell(rst_i) |-> prio[0] == 3'h4 && prio[16] == 3'h4;
   endproperty
   a_reset_level: assert property (p_reset_level) else $error("priority not at level four after reset");

   property p_disabled;
      @(posedge clk_i) disable iff (rst_i) req_o.valid |-> won_prio != iprb_pkg::PRIO_OFF && won_prio == req_o.level;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled source forwarded");

   property p_above_cpu;
      @(posedge clk_i) disable iff (rst_i) req_o.valid |-> req_o.level > $past(cpu_level);
   endproperty
   a_above_cpu: assert property (p_above_cpu) else $error("request not above cpu level");

   property p_flag_enable;
      @(posedge clk_i) disable iff (rst_i) next_req.valid |-> flag[next_req.source] && enable[next_req.source];
   endproperty
   a_flag_enable: assert property (p_flag_enable) else $error("request without flag and enable");

   property p_flag_sticky;
      @(posedge clk_i) disable iff (rst_i) event_i[0] |=> flag[0];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("event lost");

   property p_unimpl_zero;
      @(posedge clk_i) disable iff (rst_i) rd && paddr_i == iprb_pkg::ADDR_PRIO1 |-> prdata_o[3:0] == 4'h0 && !prdata_o[15];
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits not zero");

   property p_write_read;
      @(posedge clk_i) disable iff (rst_i) wr && paddr_i == iprb_pkg::ADDR_PRIO7 |=> prio[15] == $past(pwdata_i[6:4]);
   endproperty
   a_write_read: assert property (p_write_read) else $error("priority write not stored");

   property p_uart_err;
      @(posedge clk_i) disable iff (rst_i) rd && paddr_i == iprb_pkg::ADDR_PRIO16 |-> prdata_o[6:4] == prio[16];
   endproperty
   a_uart_err: assert property (p_uart_err) else $error("serial error field misplaced");

   property p_irq;
      @(posedge clk_i) disable iff (rst_i) irq_o |-> req_o.level != 3'h0;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt with zero level");

   property p_rd_timer_b;
      rd && paddr_i == iprb_pkg::ADDR_PRIO1 |-> prdata_o[14:12] == prio[iprb_pkg::S_TIMER_B];
   endproperty
   a_rd_timer_b: assert property (p_rd_timer_b) else $error("timer b field misplaced");

   property p_rd_compare_b;
      rd && paddr_i == iprb_pkg::ADDR_PRIO1 |-> prdata_o[10:8] == prio[iprb_pkg::S_COMPARE_B];
   endproperty
   a_rd_compare_b: assert property (p_rd_compare_b) else $error("compare b field misplaced");

   property p_rd_capture_b;
      rd && paddr_i == iprb_pkg::ADDR_PRIO1 |-> prdata_o[6:4] == prio[iprb_pkg::S_CAPTURE_B];
   endproperty
   a_rd_capture_b: assert property (p_rd_capture_b) else $error("capture b field misplaced");

   property p_rd_serial_rx;
      rd && paddr_i == iprb_pkg::ADDR_PRIO2 |-> prdata_o[14:12] == prio[iprb_pkg::S_SERIAL_RX];
   endproperty
   a_rd_serial_rx: assert property (p_rd_serial_rx) else $error("serial rx field misplaced");

   property p_rd_sync_evt;
      rd && paddr_i == iprb_pkg::ADDR_PRIO2 |-> prdata_o[10:8] == prio[iprb_pkg::S_SYNC_EVT];
   endproperty
   a_rd_sync_evt: assert property (p_rd_sync_evt) else $error("sync serial event field misplaced");

   property p_rd_sync_err;
      rd && paddr_i == iprb_pkg::ADDR_PRIO2 |-> prdata_o[6:4] == prio[iprb_pkg::S_SYNC_ERR];
   endproperty
   a_rd_sync_err: assert property (p_rd_sync_err) else $error("sync serial error field misplaced");

   property p_rd_timer_c;
      rd && paddr_i == iprb_pkg::ADDR_PRIO2 |-> prdata_o[2:0] == prio[iprb_pkg::S_TIMER_C];
   endproperty
   a_rd_timer_c: assert property (p_rd_timer_c) else $error("timer c field misplaced");

   property p_rd_conv_done;
      rd && paddr_i == iprb_pkg::ADDR_PRIO3 |-> prdata_o[6:4] == prio[iprb_pkg::S_CONV_DONE];
   endproperty
   a_rd_conv_done: assert property (p_rd_conv_done) else $error("converter field misplaced");

   property p_rd_serial_tx;
      rd && paddr_i == iprb_pkg::ADDR_PRIO3 |-> prdata_o[2:0] == prio[iprb_pkg::S_SERIAL_TX];
   endproperty
   a_rd_serial_tx: assert property (p_rd_serial_tx) else $error("serial tx field misplaced");

   property p_rd_pin_change;
      rd && paddr_i == iprb_pkg::ADDR_PRIO4 |-> prdata_o[14:12] == prio[iprb_pkg::S_PIN_CHANGE];
   endproperty
   a_rd_pin_change: assert property (p_rd_pin_change) else $error("pin change field misplaced");

   property p_rd_tw_master;
      rd && paddr_i == iprb_pkg::ADDR_PRIO4 |-> prdata_o[6:4] == prio[iprb_pkg::S_TW_MASTER];
   endproperty
   a_rd_tw_master: assert property (p_rd_tw_master) else $error("two-wire master field misplaced");

   property p_rd_tw_slave;
      rd && paddr_i == iprb_pkg::ADDR_PRIO4 |-> prdata_o[2:0] == prio[iprb_pkg::S_TW_SLAVE];
   endproperty
   a_rd_tw_slave: assert property (p_rd_tw_slave) else $error("two-wire slave field misplaced");

   property p_rd_capture_h;
      rd && paddr_i == iprb_pkg::ADDR_PRIO5 |-> prdata_o[14:12] == prio[iprb_pkg::S_CAPTURE_H];
   endproperty
   a_rd_capture_h: assert property (p_rd_capture_h) else $error("capture h field misplaced");

   property p_rd_capture_g;
      rd && paddr_i == iprb_pkg::ADDR_PRIO5 |-> prdata_o[10:8] == prio[iprb_pkg::S_CAPTURE_G];
   endproperty
   a_rd_capture_g: assert property (p_rd_capture_g) else $error("capture g field misplaced");

   property p_rd_ext_b;
      rd && paddr_i == iprb_pkg::ADDR_PRIO5 |-> prdata_o[2:0] == prio[iprb_pkg::S_EXT_B];
   endproperty
   a_rd_ext_b: assert property (p_rd_ext_b) else $error("external pin b field misplaced");

   property p_rd_ext_c;
      rd && paddr_i == iprb_pkg::ADDR_PRIO7 |-> prdata_o[6:4] == prio[iprb_pkg::S_EXT_C];
   endproperty
   a_rd_ext_c: assert property (p_rd_ext_c) else $error("external pin c field misplaced");

   property p_unimpl_prio1_high;
      rd && paddr_i == iprb_pkg::ADDR_PRIO1 |-> prdata_o[31:15] == 17'h0 && !prdata_o[11] && !prdata_o[7];
   endproperty
   a_unimpl_prio1_high: assert property (p_unimpl_prio1_high) else $error("register one spare bits set");

   property p_unimpl_prio2;
      rd && paddr_i == iprb_pkg::ADDR_PRIO2 |-> prdata_o[31:15] == 17'h0 && !prdata_o[11] && !prdata_o[7] && !prdata_o[3];
   endproperty
   a_unimpl_prio2: assert property (p_unimpl_prio2) else $error("register two spare bits set");

   property p_unimpl_prio3;
      rd && paddr_i == iprb_pkg::ADDR_PRIO3 |-> prdata_o[31:7] == 25'h0 && !prdata_o[3];
   endproperty
   a_unimpl_prio3: assert property (p_unimpl_prio3) else $error("register three spare bits set");

   property p_unimpl_prio4;
      rd && paddr_i == iprb_pkg::ADDR_PRIO4 |-> prdata_o[31:15] == 17'h0 && prdata_o[11:7] == 5'h0 && !prdata_o[3];
   endproperty
   a_unimpl_prio4: assert property (p_unimpl_prio4) else $error("register four spare bits set");

   property p_unimpl_prio5;
      rd && paddr_i == iprb_pkg::ADDR_PRIO5 |-> prdata_o[31:15] == 17'h0 && !prdata_o[11] && prdata_o[7:3] == 5'h0;
   endproperty
   a_unimpl_prio5: assert property (p_unimpl_prio5) else $error("register five spare bits set");

   property p_unimpl_prio7;
      rd && paddr_i == iprb_pkg::ADDR_PRIO7 |-> prdata_o[31:7] == 25'h0 && prdata_o[3:0] == 4'h0;
   endproperty
   a_unimpl_prio7: assert property (p_unimpl_prio7) else $error("register seven spare bits set");

   property p_unimpl_prio16;
      rd && paddr_i == iprb_pkg::ADDR_PRIO16 |-> prdata_o[31:7] == 25'h0 && prdata_o[3:0] == 4'h0;
   endproperty
   a_unimpl_prio16: assert property (p_unimpl_prio16) else $error("register sixteen spare bits set");

   property p_wr_timer_b;
      wr && paddr_i == iprb_pkg::ADDR_PRIO1 |=> prio[iprb_pkg::S_TIMER_B] == $past(pwdata_i[14:12]);
   endproperty
   a_wr_timer_b: assert property (p_wr_timer_b) else $error("timer b write not stored");

   property p_wr_timer_c;
      wr && paddr_i == iprb_pkg::ADDR_PRIO2 |=> prio[iprb_pkg::S_TIMER_C] == $past(pwdata_i[2:0]);
   endproperty
   a_wr_timer_c: assert property (p_wr_timer_c) else $error("timer c write not stored");

   property p_wr_serial_tx;
      wr && paddr_i == iprb_pkg::ADDR_PRIO3 |=> prio[iprb_pkg::S_SERIAL_TX] == $past(pwdata_i[2:0]);
   endproperty
   a_wr_serial_tx: assert property (p_wr_serial_tx) else $error("serial tx write not stored");

   property p_wr_tw_master;
      wr && paddr_i == iprb_pkg::ADDR_PRIO4 |=> prio[iprb_pkg::S_TW_MASTER] == $past(pwdata_i[6:4]);
   endproperty
   a_wr_tw_master: assert property (p_wr_tw_master) else $error("two-wire master write not stored");

   property p_wr_capture_g;
      wr && paddr_i == iprb_pkg::ADDR_PRIO5 |=> prio[iprb_pkg::S_CAPTURE_G] == $past(pwdata_i[10:8]);
   endproperty
   a_wr_capture_g: assert property (p_wr_capture_g) else $error("capture g write not stored");

   property p_wr_serial_err;
      wr && paddr_i == iprb_pkg::ADDR_PRIO16 |=> prio[iprb_pkg::S_SERIAL_ERR] == $past(pwdata_i[6:4]);
   endproperty
   a_wr_serial_err: assert property (p_wr_serial_err) else $error("serial error write not stored");

   property p_flag_clear;
      wr && paddr_i == iprb_pkg::ADDR_FLAG && pwdata_i[3] && !event_i[3] |=> !flag[3];
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by write");

   property p_flag_hold;
      flag[5] |=> flag[5] || $past(wr && paddr_i == iprb_pkg::ADDR_FLAG && pwdata_i[5]);
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");

   property p_enable_block;
      enable == '0 |=> !req_o.valid;
   endproperty
   a_enable_block: assert property (p_enable_block) else $error("request forwarded with no enable");

   property p_zero_block;
      next_req.valid && prio[iprb_pkg::S_TIMER_B] == iprb_pkg::PRIO_OFF |-> next_req.source != 5'(iprb_pkg::S_TIMER_B);
   endproperty
   a_zero_block: assert property (p_zero_block) else $error("source at level zero won");

   property p_tie_low;
      next_req.valid && flag[0] && enable[0] && prio[0] >= next_req.level |-> next_req.source == 5'h0;
   endproperty
   a_tie_low: assert property (p_tie_low) else $error("lowest source lost an equal level");
endmodule : iprb_bank

// ==== test/iprb_core_model.sv ====
// Core-side model that takes the forwarded request while the interrupt line is raised.
`timescale 1ns/1ps
module iprb_core_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire iprb_pkg::iprb_req_s req_i,
   input wire logic irq_i,
   output iprb_pkg::iprb_req_s taken_o
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         taken_o <= '0;
      end else if (irq_i) begin
         taken_o <= req_i;
      end
   end
endmodule : iprb_core_model

// ==== test/iprb_bank_tb_top.sv ====
// Self-checking testbench of the interrupt priority bank.
`timescale 1ns/1ps
module iprb_bank_tb_top;
   localparam logic [11:0] AD [7] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018};
   localparam logic [15:0] MK [7] = '{16'h7770, 16'h7777, 16'h0077, 16'h7077, 16'h7707, 16'h0070, 16'h0070};
   localparam int SR [17] = '{0, 0, 0, 1, 1, 1, 1, 2, 2, 3, 3, 3, 4, 4, 4, 5, 6};
   localparam int SH [17] = '{12, 8, 4, 12, 8, 4, 0, 4, 0, 12, 4, 0, 12, 8, 0, 4, 4};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   logic [16:0] event_i = 17'h0;
   logic irq_o;
   iprb_pkg::iprb_req_s req_o;
   iprb_pkg::iprb_req_s seen;
   iprb_pkg::iprb_req_s exp_w;
   int fails = 0;
   int checked = 0;
   int k;
   logic [15:0] lfsr = 16'h4F5A;
   logic [15:0] shadow [7];
   logic [31:0] rd;
   logic err;
   logic [16:0] flg;
   logic [16:0] ena;
   logic [2:0] cpu;
   always #25 clk_i = ~clk_i;
   iprb_bank i_iprb_bank (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .event_i(event_i), .req_o(req_o), .irq_o(irq_o));
   iprb_core_model i_iprb_core_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_o), .irq_i(irq_o), .taken_o(seen));
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : nxt
   // Highest level above the core level wins; the scan keeps the lower index on a tie.
   function automatic iprb_pkg::iprb_req_s win(input logic [16:0] f, input logic [16:0] e, input logic [2:0] c);
      iprb_pkg::iprb_req_s w;
      logic [2:0] l;
      w = '0;
      for (int s = 0; s < iprb_pkg::NSRC; s++) begin
         l = shadow[SR[s]][SH[s] +: 3];
         if (f[s] && e[s] && l > c && l > w.level) begin
            w = '{1'b1, 5'(s), l};
         end
      end
      return w;
   endfunction : win
   task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1) @(posedge clk_i);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask : apb
   task automatic finish_test;
      if (fails == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      #200000;
      fails++;
      finish_test();
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         apb(1'b0, AD[i], 32'h0);
         chk("prio reset", {16'h0, MK[i] & 16'h4444}, rd);
         shadow[i] = MK[i] & 16'h4444;
      end
      repeat (4) for (int i = 0; i < 7; i++) begin
         lfsr = nxt(lfsr);
         apb(1'b1, AD[i], {lfsr, lfsr});
         apb(1'b0, AD[i], 32'h0);
         chk("prio rw", {16'h0, lfsr & MK[i]}, rd);
         chk("slverr", 32'h0, {31'h0, err});
         shadow[i] = lfsr & MK[i];
      end
      apb(1'b0, 12'h01C, 32'h0);
      chk("unmapped", 32'h1, {rd[30:0], err});
      for (int it = 0; it < 14; it++) begin
         lfsr = nxt(lfsr);
         k = lfsr[2:0] % 7;
         apb(1'b1, AD[k], {16'h0, lfsr});
         shadow[k] = lfsr & MK[k];
         cpu = (it == 0) ? 3'h0 : lfsr[5:3];
         apb(1'b1, iprb_pkg::ADDR_CPU_LEVEL, {29'h0, cpu});
         apb(1'b1, iprb_pkg::ADDR_FLAG, 32'h1FFFF);
         lfsr = nxt(lfsr);
         ena = (it == 0) ? 17'h1FFFF : {lfsr[3], lfsr};
         apb(1'b1, iprb_pkg::ADDR_ENABLE, {15'h0, ena});
         lfsr = nxt(lfsr);
         flg = (it == 0) ? 17'h1FFFF : {lfsr[7], lfsr};
         event_i <= flg;
         @(posedge clk_i);
         event_i <= 17'h0;
         repeat (3) @(posedge clk_i);
         exp_w = win(flg, ena, cpu);
         chk("winner", {23'h0, exp_w}, {23'h0, req_o});
         chk("irq", {31'h0, exp_w.valid}, {31'h0, irq_o});
         if (exp_w.valid) chk("core taken", {23'h0, exp_w}, {23'h0, seen});
         apb(1'b0, iprb_pkg::ADDR_STATUS, 32'h0);
         chk("status", {23'h0, exp_w}, rd);
         apb(1'b1, iprb_pkg::ADDR_FLAG, 32'h1FFFF);
         repeat (2) @(posedge clk_i);
         chk("irq cleared", 32'h0, {31'h0, irq_o});
      end
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         apb(1'b0, AD[i], 32'h0);
         chk("prio rereset", {16'h0, MK[i] & 16'h4444}, rd);
      end
      chk("irq after reset", 32'h0, {31'h0, irq_o});
      finish_test();
   end
endmodule : iprb_bank_tb_top
